// ==== include/acp_pkg.sv ====
// Functional notes
// - lock status bit is read-only, shows lock
// - divider source: aux oscillators or primary vco
// - output divider code 111 divides by one
// - pll input: fast rc, primary, or none
// - output enable drives divided reference clock
// - run-in-sleep keeps reference output alive
// - reference divider divides by two to code
// - sleep operand stops clocks and execution
// - idle halts cpu, peripherals keep clock
// - wake on interrupt, reset or watchdog
// - sleep shuts system clock and oscillator
// - clock monitor inactive throughout sleep
// - sleep keeps low-power rc only with watchdog
// - watchdog cleared on entering sleep or idle
// - sleep disables system-clocked peripherals
// - wake resumes with the same clock source
// - regulators standby in sleep unless kept
// - idle keeps low-power rc for watchdog/monitor
// - idle wake resumes execution two cycles later
// - peripherals get an idle stop indication
// - coincident interrupt held, then immediate wake
package acp_pkg;
   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  OFF_AUX     = 8'h00;
   localparam logic [7:0]  OFF_REF     = 8'h04;
   localparam logic [7:0]  OFF_PWR     = 8'h08;
   localparam logic [7:0]  OFF_STAT    = 8'h0c;
   localparam logic [15:0] AUX_RST     = 16'h2700;
   localparam logic [15:0] AUX_WMASK   = 16'ha7c0;
   localparam logic [15:0] REF_RST     = 16'h0000;
   localparam logic [15:0] REF_WMASK   = 16'hbf00;
   localparam logic [15:0] PWR_RST     = 16'h0000;
   localparam logic [15:0] PWR_WMASK   = 16'h0900;
   localparam int          B_PLL_EN    = 15;
   localparam int          B_LOCK      = 14;
   localparam int          B_DIV_SRC   = 13;
   localparam int          B_PRI_SEL   = 7;
   localparam int          B_FRC_SEL   = 6;
   localparam int          B_REF_ON    = 15;
   localparam int          B_REF_SLP   = 13;
   localparam int          B_CORE_KEEP = 8;
   localparam int          B_FLSH_KEEP = 11;
   localparam int          F_AUX_DIV   = 8;
   localparam int          F_REF_DIV   = 8;
   localparam logic [2:0]  WAKE_CYC    = 3'h2;
   localparam logic [1:0]  RESP_OK     = 2'h0;
   localparam logic [1:0]  RESP_ERR    = 2'h2;
   localparam logic [1:0]  SRC_NONE    = 2'h0;
   localparam logic [1:0]  SRC_PRI     = 2'h1;
   localparam logic [1:0]  SRC_FRC     = 2'h2;
   localparam logic [1:0]  WK_NONE     = 2'h0;
   localparam logic [1:0]  WK_IRQ      = 2'h1;
   localparam logic [1:0]  WK_WDT      = 2'h2;

   typedef enum logic [2:0] {PS_RUN, PS_ENTER, PS_SLEEP, PS_IDLE, PS_WAKE} acp_pst_t;

   typedef struct packed {
      logic       aux_pll_power;
      logic [1:0] aux_pll_src;
      logic       aux_div_src;
      logic [2:0] aux_div_shift;
      logic       ref_out_en;
      logic       ref_clk;
      logic       cpu_clk_en;
      logic       cpu_halted;
      logic       sys_clk_off;
      logic       osc_off;
      logic       fail_safe_clock_monitor_active;
      logic       low_power_rc_clock_en;
      logic       wdt_clear;
      logic       periph_clk_en;
      logic       periph_idle;
      logic       core_reg_stby;
      logic       flash_reg_stby;
      logic [2:0] resume_clk_sel;
      logic       resume;
      logic       resume_to_isr;
   } acp_ctl_t;
endpackage : acp_pkg

// ==== hw/acp_top.sv ====
`timescale 1ns/1ps
module acp_top
   import acp_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   input  wire logic              pll_lock_pin,
   input  wire logic              ps_req,
   input  wire logic              ps_sleep,
   input  wire logic              irq_wake,
   input  wire logic              wdt_timeout,
   input  wire logic              wdt_enable,
   input  wire logic              fail_safe_clock_monitor_enable,
   input  wire logic [2:0]        sys_clk_sel,
   output acp_ctl_t               ctl
);

   typedef struct packed {
      logic              awrdy;
      logic              wrdy;
      logic              arrdy;
      logic              awv;
      logic              wv;
      logic [ADDR_W-1:0] awa;
      logic [15:0]       wd;
      logic [1:0]        ws;
      logic              bv;
      logic [1:0]        br;
      logic              rv;
      logic [15:0]       rd;
      logic [1:0]        rr;
      logic [15:0]       aux;
      logic [15:0]       refc;
      logic [15:0]       pwr;
      logic              lk1;
      logic              lk2;
      logic [14:0]       rcnt;
      acp_pst_t          pst;
      logic              mode_sleep;
      logic              pend;
      logic [2:0]        wcnt;
      logic [1:0]        cause;
      logic [2:0]        clksel;
      acp_ctl_t          ctl;
   } acp_state_t;

   acp_state_t s_r;
   acp_state_t s_nxt;

   logic [15:0] wmask;
   logic [15:0] aux_rd;
   logic [15:0] stat_rd;
   logic [14:0] div_mask;
   logic        locked;
   logic        in_sleep;
   logic        in_idle;
   logic        ref_act;

   always_comb begin
      s_nxt   = s_r;
      wmask   = {{8{s_r.ws[1]}}, {8{s_r.ws[0]}}};
      // aux lock bit only counts while the pll is enabled; stale lock is masked there, the status register shows lk2 unmasked
      locked  = s_r.aux[B_PLL_EN] & s_r.lk2;
      aux_rd  = s_r.aux;
      aux_rd[B_LOCK] = locked;
      stat_rd = {8'h00, s_r.lk2, s_r.pend, s_r.cause, 1'b0, s_r.pst};
      s_nxt.ctl.wdt_clear = 1'b0;
      s_nxt.ctl.resume    = 1'b0;

      // pin synchroniser; first stage feeds only the second
      s_nxt.lk1 = pll_lock_pin;
      s_nxt.lk2 = s_r.lk1;

      // write address and data are taken independently
      if (awvalid && s_r.awrdy) begin
         s_nxt.awv = 1'b1;
         s_nxt.awa = awaddr;
      end
      if (wvalid && s_r.wrdy) begin
         s_nxt.wv = 1'b1;
         s_nxt.wd = wdata[15:0];
         s_nxt.ws = wstrb[1:0];
      end
      if (bready && s_r.bv) begin
         s_nxt.bv = 1'b0;
      end
      if (s_r.awv && s_r.wv && !s_r.bv) begin
         s_nxt.awv = 1'b0;
         s_nxt.wv  = 1'b0;
         s_nxt.bv  = 1'b1;
         s_nxt.br  = RESP_OK;
         case (s_r.awa)
            OFF_AUX: begin
               s_nxt.aux = (s_r.aux & ~(wmask & AUX_WMASK)) | (s_r.wd & wmask & AUX_WMASK);
            end
            OFF_REF: begin
               // divider writes are taken even while enabled; software must not do that
               s_nxt.refc = (s_r.refc & ~(wmask & REF_WMASK)) | (s_r.wd & wmask & REF_WMASK);
            end
            OFF_PWR: begin
               s_nxt.pwr = (s_r.pwr & ~(wmask & PWR_WMASK)) | (s_r.wd & wmask & PWR_WMASK);
            end
            OFF_STAT: begin
               s_nxt.br = RESP_OK;
            end
            default: begin
               s_nxt.br = RESP_ERR;
            end
         endcase
      end

      // read answers one cycle after the address is taken
      if (arvalid && s_r.arrdy) begin
         s_nxt.rv = 1'b1;
         s_nxt.rr = RESP_OK;
         case (araddr)
            OFF_AUX: begin
               s_nxt.rd = aux_rd;
            end
            OFF_REF: begin
               s_nxt.rd = s_r.refc;
            end
            OFF_PWR: begin
               s_nxt.rd = s_r.pwr;
            end
            OFF_STAT: begin
               s_nxt.rd = stat_rd;
            end
            default: begin
               s_nxt.rd = 16'h0000;
               s_nxt.rr = RESP_ERR;
            end
         endcase
      end else if (rready && s_r.rv) begin
         s_nxt.rv = 1'b0;
      end

      // power-save sequencer
      case (s_r.pst)
         PS_RUN: begin
            if (ps_req) begin
               s_nxt.pst        = PS_ENTER;
               s_nxt.mode_sleep = ps_sleep;
               s_nxt.clksel     = sys_clk_sel;
               s_nxt.ctl.wdt_clear = wdt_enable;
               s_nxt.pend       = irq_wake;
            end
         end
         PS_ENTER: begin
            // an interrupt during entry is held, not acted on yet
            s_nxt.pend = s_r.pend | irq_wake;
            if (s_r.mode_sleep) begin
               s_nxt.pst = PS_SLEEP;
            end else begin
               s_nxt.pst = PS_IDLE;
            end
         end
         PS_SLEEP, PS_IDLE: begin
            if (s_r.pend || irq_wake || wdt_timeout) begin
               s_nxt.pst  = PS_WAKE;
               s_nxt.wcnt = WAKE_CYC;
               s_nxt.pend = 1'b0;
               if (s_r.pend || irq_wake) begin
                  s_nxt.cause = WK_IRQ;
               end else begin
                  s_nxt.cause = WK_WDT;
               end
            end
         end
         PS_WAKE: begin
            // clock is back on the cpu here; execution restarts after the count
            if (s_r.wcnt <= 3'h1) begin
               s_nxt.pst = PS_RUN;
               s_nxt.ctl.resume = 1'b1;
               s_nxt.ctl.resume_to_isr = (s_r.cause == WK_IRQ);
            end else begin
               s_nxt.wcnt = s_r.wcnt - 3'h1;
            end
         end
         default: begin
            s_nxt.pst = PS_RUN;
         end
      endcase

      in_sleep = (s_nxt.pst == PS_SLEEP);
      in_idle  = (s_nxt.pst == PS_IDLE);

      s_nxt.ctl.cpu_clk_en    = (s_nxt.pst == PS_RUN) || (s_nxt.pst == PS_WAKE);
      s_nxt.ctl.cpu_halted    = (s_nxt.pst != PS_RUN);
      s_nxt.ctl.sys_clk_off   = in_sleep;
      s_nxt.ctl.osc_off       = in_sleep;
      s_nxt.ctl.periph_clk_en = !in_sleep;
      s_nxt.ctl.periph_idle   = in_idle;
      s_nxt.ctl.fail_safe_clock_monitor_active   = fail_safe_clock_monitor_enable && !in_sleep;
      if (in_sleep) begin
         s_nxt.ctl.low_power_rc_clock_en = wdt_enable;
      end else begin
         s_nxt.ctl.low_power_rc_clock_en = wdt_enable || fail_safe_clock_monitor_enable;
      end
      s_nxt.ctl.core_reg_stby  = in_sleep && !s_r.pwr[B_CORE_KEEP];
      s_nxt.ctl.flash_reg_stby = in_sleep && !s_r.pwr[B_FLSH_KEEP];
      s_nxt.ctl.resume_clk_sel = s_nxt.clksel;

      // auxiliary clock path
      s_nxt.ctl.aux_pll_power = s_nxt.aux[B_PLL_EN];
      if (!s_nxt.aux[B_PLL_EN]) begin
         s_nxt.ctl.aux_pll_src = SRC_NONE;
      end else if (s_nxt.aux[B_FRC_SEL]) begin
         s_nxt.ctl.aux_pll_src = SRC_FRC;
      end else if (s_nxt.aux[B_PRI_SEL]) begin
         s_nxt.ctl.aux_pll_src = SRC_PRI;
      end else begin
         s_nxt.ctl.aux_pll_src = SRC_NONE;
      end
      s_nxt.ctl.aux_div_src   = s_nxt.aux[B_DIV_SRC];
      // shift count: code 111 divides by one, each step down doubles
      s_nxt.ctl.aux_div_shift = ~s_nxt.aux[F_AUX_DIV +: 3];

      // reference output: one-cycle pulse every 2^n clocks, so code 0 is steady high
      ref_act  = s_nxt.refc[B_REF_ON] && (!in_sleep || s_nxt.refc[B_REF_SLP]);
      div_mask = ~(15'h7fff << s_nxt.refc[F_REF_DIV +: 4]);
      s_nxt.ctl.ref_out_en = ref_act;
      if (ref_act) begin
         s_nxt.rcnt = s_r.rcnt + 15'h0001;
         s_nxt.ctl.ref_clk = ((s_r.rcnt & div_mask) == 15'h0000);
      end else begin
         s_nxt.rcnt = 15'h0000;
         s_nxt.ctl.ref_clk = 1'b0;
      end

      s_nxt.awrdy = !s_nxt.awv && !s_nxt.bv;
      s_nxt.wrdy  = !s_nxt.wv && !s_nxt.bv;
      s_nxt.arrdy = !s_nxt.rv;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // any device reset also ends sleep or idle
         s_r                   <= '0;
         s_r.awrdy             <= 1'b1;
         s_r.wrdy              <= 1'b1;
         s_r.arrdy             <= 1'b1;
         s_r.aux               <= AUX_RST;
         s_r.refc              <= REF_RST;
         s_r.pwr               <= PWR_RST;
         s_r.pst               <= PS_RUN;
         s_r.ctl.aux_div_src   <= AUX_RST[B_DIV_SRC];
         s_r.ctl.cpu_clk_en    <= 1'b1;
         s_r.ctl.periph_clk_en <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign awready = s_r.awrdy;
   assign wready  = s_r.wrdy;
   assign bvalid  = s_r.bv;
   assign bresp   = s_r.br;
   assign arready = s_r.arrdy;
   assign rvalid  = s_r.rv;
   assign rdata   = {16'h0000, s_r.rd};
   assign rresp   = s_r.rr;
   assign ctl     = s_r.ctl;

endmodule : acp_top

// ==== bench/acp_top_sva.sv ====
`timescale 1ns/1ps
module acp_top_sva
   import acp_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       ps_req,
   input wire logic       ps_sleep,
   input wire logic       irq_wake,
   input wire logic       wdt_timeout,
   input wire logic       wdt_enable,
   input wire logic       fail_safe_clock_monitor_enable,
   input wire logic [2:0] sys_clk_sel,
   input acp_ctl_t        ctl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // requests outside run are refused, so only a run-state request counts
   sequence s_enter;
      ps_req && !ctl.cpu_halted;
   endsequence
   sequence s_saving;
      ctl.sys_clk_off || ctl.periph_idle;
   endsequence
   a_sleep_gates: assert property (
      ctl.sys_clk_off |-> ctl.osc_off && !ctl.periph_clk_en && !ctl.fail_safe_clock_monitor_active) else $error("sleep clock on");
   a_low_power_rc_clock_sleep: assert property (
      ctl.sys_clk_off && $stable(wdt_enable) |-> ctl.low_power_rc_clock_en == wdt_enable) else $error("sleep low_power_rc_clock");
   a_low_power_rc_clock_idle: assert property (
      ctl.periph_idle && $stable(wdt_enable) && $stable(fail_safe_clock_monitor_enable) |-> ctl.low_power_rc_clock_en == (wdt_enable | fail_safe_clock_monitor_enable))
      else $error("idle low_power_rc_clock");
   a_wdt_clear: assert property (
      s_enter |=> ctl.wdt_clear == $past(wdt_enable)) else $error("watchdog clear");
   a_mode_entry: assert property (
      s_enter |=> ctl.cpu_halted && !ctl.cpu_clk_en ##1
      ctl.sys_clk_off == $past(ps_sleep, 2) && ctl.periph_idle != $past(ps_sleep, 2)) else $error("mode entry");
   a_coincident_irq: assert property (
      s_enter ##0 irq_wake |=> !ctl.cpu_clk_en ##1 s_saving ##1 ctl.cpu_clk_en) else $error("held interrupt");
   a_wake_event: assert property (
      s_saving ##0 (irq_wake || wdt_timeout) |=> ctl.cpu_clk_en && !ctl.sys_clk_off && !ctl.periph_idle)
      else $error("no wake");
   a_resume_delay: assert property (
      ctl.cpu_halted && $rose(ctl.cpu_clk_en) |-> !ctl.resume [*2] ##1 ctl.resume && !ctl.cpu_halted)
      else $error("resume timing");
   a_resume_src: assert property (
      s_enter |=> ctl.resume_clk_sel == $past(sys_clk_sel)) else $error("resume source");
   a_ref_gated: assert property (
      !ctl.ref_out_en |-> !ctl.ref_clk) else $error("ref pulse while off");
   a_pll_off: assert property (
      !ctl.aux_pll_power |-> ctl.aux_pll_src == SRC_NONE) else $error("pll input while off");
endmodule : acp_top_sva

bind acp_top acp_top_sva u_sva (.clk, .rst_b, .ps_req, .ps_sleep, .irq_wake, .wdt_timeout, .wdt_enable,
   .fail_safe_clock_monitor_enable, .sys_clk_sel, .ctl);

// ==== bench/test_aux_refclk_power_save.sv ====
`timescale 1ns/1ps
module test_aux_refclk_power_save
   import acp_pkg::*;
;
   typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e; logic [1:0] r;} acp_row_t;
   logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic        pll_lock_pin, ps_req, ps_sleep, irq_wake, wdt_timeout, wdt_enable, fail_safe_clock_monitor_enable, e_ref;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, rsp, e_stb;
   logic [2:0]  sys_clk_sel;
   logic [15:0] rv;
   logic [3:0]  cd [4] = '{4'h0, 4'h1, 4'h9, 4'hf};
   acp_ctl_t    ctl;
   int          bad_count, checks_done, cyc;
   acp_row_t    rows [8] = '{'{8'h00, 16'hffff, 16'he7c0, RESP_OK}, '{8'h00, 16'h0000, 16'h0000, RESP_OK},
      '{8'h04, 16'h3f00, 16'h3f00, RESP_OK}, '{8'h04, 16'h0000, 16'h0000, RESP_OK},
      '{8'h08, 16'hffff, 16'h0900, RESP_OK}, '{8'h20, 16'hffff, 16'h0000, RESP_ERR},
      '{8'h02, 16'hffff, 16'h0000, RESP_ERR}, '{8'h0c, 16'hffff, 16'h0080, RESP_OK}};

   acp_top dut (.clk, .rst_b, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
      .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
      .rdata, .rresp, .pll_lock_pin, .ps_req, .ps_sleep, .irq_wake, .wdt_timeout, .wdt_enable, .fail_safe_clock_monitor_enable,
      .sys_clk_sel, .ctl);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // address and data go out together, the slave may take them at different edges
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {16'h0, d};
      bready <= 1'b1;
      fork
         begin
            do @(posedge clk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge clk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge clk); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rv = rdata[15:0];
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd

   task pwr(input logic s, input logic early, input logic by_irq);
      int n;
      @(posedge clk);
      ps_req <= 1'b1;
      ps_sleep <= s;
      irq_wake <= early;
      @(posedge clk);
      ps_req <= 1'b0;
      #1 chk({ctl.wdt_clear, ctl.cpu_halted}, {wdt_enable, 1'b1});
      @(posedge clk);
      #1 chk({ctl.sys_clk_off, ctl.periph_idle, ctl.periph_clk_en}, {s, !s, !s});
      chk(ctl.low_power_rc_clock_en, s ? wdt_enable : (wdt_enable | fail_safe_clock_monitor_enable));
      chk({ctl.flash_reg_stby, ctl.core_reg_stby, ctl.ref_out_en}, {e_stb, e_ref});
      @(posedge clk);
      if (by_irq) irq_wake <= 1'b1;
      else wdt_timeout <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ctl.resume !== 1'b1 && n < 20);
      irq_wake <= 1'b0;
      wdt_timeout <= 1'b0;
      chk({n < 20, ctl.resume_to_isr, ctl.resume_clk_sel}, {1'b1, by_irq, sys_clk_sel});
      $display("test power save %0d done", s);
   endtask : pwr

   task final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   // a hang anywhere ends up here instead of running forever
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         final_report();
      end
   end

   initial begin
      int n;
      {rst_b, awvalid, wvalid, bready, arvalid, rready, ps_req, ps_sleep, irq_wake, wdt_timeout} = '0;
      {awaddr, araddr, wdata} = '0;
      {pll_lock_pin, wdt_enable, fail_safe_clock_monitor_enable} = 3'h7;
      sys_clk_sel = 3'h5;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(OFF_AUX);
      chk({rv, rsp, ctl.aux_div_src}, {AUX_RST, RESP_OK, 1'b1});
      rd(OFF_REF);
      chk(rv, REF_RST);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk(rsp, rows[i].r);
         rd(rows[i].a);
         chk({rv, rsp}, {rows[i].e, rows[i].r});
      end
      $display("test register rows done");
      for (int i = 0; i < 8; i++) begin
         wr(OFF_AUX, {2'b10, i[0], 2'b00, i[2:0], i[1:0], 6'h00});
         chk({ctl.aux_pll_power, ctl.aux_div_src, ctl.aux_div_shift}, {1'b1, i[0], ~i[2:0]});
         chk(ctl.aux_pll_src, i[0] ? SRC_FRC : (i[1] ? SRC_PRI : SRC_NONE));
      end
      // lock status follows the synchronised pin while the pll stays enabled
      pll_lock_pin <= 1'b0;
      repeat (2) @(posedge clk);
      rd(OFF_AUX);
      chk(rv, 16'ha7c0);
      pll_lock_pin <= 1'b1;
      $display("test aux clock done");
      // divider only changes while the output is off
      foreach (cd[k]) begin
         wr(OFF_REF, {4'h0, cd[k], 8'h00});
         wr(OFF_REF, {4'h8, cd[k], 8'h00});
         while (ctl.ref_clk !== 1'b1) @(posedge clk);
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (ctl.ref_clk !== 1'b1);
         chk(n, 1 << cd[k]);
         wr(OFF_REF, {4'h0, cd[k], 8'h00});
      end
      $display("test reference divider done");
      wr(OFF_REF, 16'h0000);
      wr(OFF_REF, 16'h8000);
      e_stb = 2'h0;
      e_ref = 1'b1;
      pwr(1'b0, 1'b0, 1'b1);
      wdt_enable <= 1'b0;
      e_ref = 1'b0;
      pwr(1'b1, 1'b0, 1'b0);
      wr(OFF_PWR, 16'h0000);
      wr(OFF_REF, 16'ha000);
      e_stb = 2'h3;
      e_ref = 1'b1;
      pwr(1'b1, 1'b1, 1'b1);
      {wdt_enable, fail_safe_clock_monitor_enable} <= 2'h2;
      e_stb = 2'h0;
      pwr(1'b0, 1'b0, 1'b0);
      // a reset in the middle of sleep must wake the device and restore the registers
      @(posedge clk);
      ps_req <= 1'b1;
      ps_sleep <= 1'b1;
      @(posedge clk);
      ps_req <= 1'b0;
      @(posedge clk);
      #1 chk({ctl.sys_clk_off, ctl.low_power_rc_clock_en}, 2'h3);
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1 chk({ctl.cpu_clk_en, ctl.cpu_halted, ctl.sys_clk_off, ctl.ref_out_en}, 4'h8);
      @(posedge clk);
      rst_b <= 1'b1;
      rd(OFF_REF);
      chk({rv, rsp}, {REF_RST, RESP_OK});
      rd(OFF_STAT);
      chk(rv, 16'h0080);
      $display("test reset in sleep done");
      final_report();
   end
endmodule : test_aux_refclk_power_save
